/* core/epm_defines.svh */
/*
 * Offsets, field positions, vector numbers, ranks and reset values of the
 * exception priority model.
 * Assumes it is included by bare name from files compiled after it.
 */
`ifndef EPM_DEFINES_SVH
`define EPM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EPM_OFF_CTRL_STATE 8'h00
`define EPM_OFF_SYS_CTRL 8'h04
`define EPM_OFF_SYS_PRI 8'h08
`define EPM_OFF_GROUP 8'h0c
`define EPM_OFF_SET_EN 8'h10
`define EPM_OFF_CLR_EN 8'h14
`define EPM_OFF_SET_PEND 8'h18
`define EPM_OFF_CLR_PEND 8'h1c
`define EPM_OFF_PRIO0 8'h20
`define EPM_OFF_PRIO3 8'h2c
`define EPM_OFF_ACT_IRQ 8'h30
`define EPM_OFF_SYS_STAT 8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EPM_CS_NMI_SET 31
`define EPM_CS_PEND_SET 28
`define EPM_CS_PEND_CLR 27
`define EPM_CS_TICK_SET 26
`define EPM_CS_TICK_CLR 25
`define EPM_CS_SEL_LSB 12
`define EPM_SC_LSB 16
`define EPM_SC_MEM_EN 0
`define EPM_SC_BUS_EN 1
`define EPM_SC_USE_EN 2
`define EPM_SC_DBG_EN 3
`define EPM_SC_UNALIGN 4
`define EPM_SC_DIV0 5

// ----------------------------------------------------------------------
// Vector numbers, ranks and addresses
// ----------------------------------------------------------------------
`define EPM_VEC_NMI 6'h02
`define EPM_VEC_HARD 6'h03
`define EPM_VEC_MEM 6'h04
`define EPM_VEC_BUS 6'h05
`define EPM_VEC_USE 6'h06
`define EPM_VEC_SUPCALL 6'h0b
`define EPM_VEC_DBG 6'h0c
`define EPM_VEC_PENDSRV 6'h0e
`define EPM_VEC_TICK 6'h0f
`define EPM_VEC_IRQ0 16
`define EPM_NUM_IRQ 31
`define EPM_NUM_VEC 48
`define EPM_RANK_NMI 4'h1
`define EPM_RANK_HARD 4'h2
`define EPM_RANK_PROG 4'h3
`define EPM_RANK_NONE 4'hf
`define EPM_ADDR_SP 8'h00
`define EPM_ADDR_RESET 8'h04
`define EPM_PRI_RST 3'h0

`endif

/* core/epm_pkg.sv */
/*
 * Types of the exception priority model: state machine, bus request,
 * event inputs, core outputs and the whole state record.
 * Assumes nothing of its surroundings.
 */
package epm_pkg;
    typedef enum logic [2:0] {ST_SP = 3'b001, ST_PC = 3'b010, ST_RUN = 3'b100} epm_st_t;
    typedef struct packed {
        logic [7:0] addr; logic [31:0] wdata; logic wr; logic rd;
    } epm_bus_t;
    typedef struct packed {
        logic entry_err; logic exec_never_fetch; logic prot_viol; logic bus_precise;
        logic bus_imprecise; logic undef; logic unalign_illegal; logic bad_state;
        logic bad_return; logic unalign_wh; logic div_zero; logic supcall_exec;
        logic dbg_req; logic tick_zero; logic tick_int_en;
    } epm_evt_t;
    typedef struct packed {
        logic halted; logic sp_load; logic fetch; logic [7:0] fetch_addr;
        logic push; logic pop; logic tail; logic [5:0] vec; logic handler;
    } epm_out_t;
    typedef struct packed {
        epm_st_t st; logic [2:0] nmi_s; logic nmi_lvl; logic [30:0] irq_prev;
        logic [47:0] pend; logic [47:0] act; logic [30:0] en; logic [30:0][2:0] pri;
        logic [6:0][2:0] shp; logic [5:0] shen; logic [1:0] grp; logic [31:0] rdata;
        epm_out_t o;
    } epm_state_t;
endpackage : epm_pkg

/* core/epm_core.sv */
/*
 * Exception priority model: pending and active tracking, priority
 * selection, nesting, tail-chaining and reset boot sequence.
 * Assumes the core pulses exc_return at handler end and instr_boundary
 * between instructions, and a register master on the same clock.
 */
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "epm_defines.svh"

// What this block does
// - Eight programmable levels for seven system handlers and 31 interrupts.
// - Programmable level 0 ranks fourth, after reset, unmaskable and hard fault.
// - All programmable priorities read zero after reset.
// - Each exception is inactive, pending, active or active-and-pending.
// - Peripheral or software request makes the interrupt pending.
// - A nested handler leaves both exceptions marked active.
// - Reset halts anywhere; release boots privileged thread mode from reset vector.
// - Reset ranks highest; stack pointer loads from the first vector entry.
// - Unmaskable interrupt from pin or software bit, fixed rank, never masked.
// - Hard fault on entry error or unhandleable fault, above all programmable.
// - Execute-never fetch raises memory fault, vector 4, even without protection.
// - Bus fault, vector 5, enableable; precise synchronous, imprecise asynchronous.
// - Usage fault, vector 6, for listed causes; unaligned and divide when configured.
// - Supervisor call instruction raises vector 11 synchronously.
// - Debug monitor, vector 12, only when enabled and more urgent than current.
// - Pendable service only from control-state register; tick may be set there.
// - Timer reaching zero raises tick when its interrupt is enabled.
// - Asynchronous entry waits for an instruction boundary, one more instruction.
// - Software disables configurable exceptions through control and clear-enable.
// - Entry pushes state while fetching the vector; handler end pops it.
// - Pending exception at exit chains straight in without pop and push.
// - Set-enable, per-interrupt priority, and preempt/subpriority grouping.
// - Interrupts use vectors 16 and up, vector addresses from 0x40.
module epm_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire epm_pkg::epm_bus_t bus,
    output logic [31:0] rdata,
    input wire logic nmi_pin,
    input wire logic [30:0] irq_in,
    input wire logic instr_boundary,
    input wire logic exc_return,
    input wire epm_pkg::epm_evt_t evt,
    output epm_pkg::epm_out_t core_out
);
    // ------------------------------------------------------------------
    // Vector attributes
    // ------------------------------------------------------------------
    localparam logic [6:0][5:0] SYS_VEC = {`EPM_VEC_TICK, `EPM_VEC_PENDSRV, `EPM_VEC_DBG,
        `EPM_VEC_SUPCALL, `EPM_VEC_USE, `EPM_VEC_BUS, `EPM_VEC_MEM};
    localparam logic [3:0][5:0] FLT_VEC = {`EPM_VEC_SUPCALL, `EPM_VEC_USE, `EPM_VEC_BUS,
        `EPM_VEC_MEM};

    epm_pkg::epm_state_t q;
    epm_pkg::epm_state_t d;
    logic [47:0][2:0] pri_v;
    logic [47:0][3:0] fix_v;
    logic [47:0][3:0] full_v;
    logic [47:0][3:0] pre_v;
    logic [47:0] prog_v;
    logic [47:0] en_v;
    logic [47:0] set_v;
    logic [47:0] clr_v;
    logic [47:0] aset_v;
    logic [47:0] aclr_v;
    logic [3:0] freq;
    logic use_req;
    logic sel_ok;
    logic cur_ok;
    logic [5:0] sel_vec;
    logic [5:0] cur_vec;
    logic [3:0] sel_full;
    logic [3:0] cur_full;
    logic [3:0] cur_pre;
    logic [3:0] aft_pre;
    logic [3:0] sel_pre;
    logic preempt_ok;
    logic chain_ok;

    // Maps each vector to its priority source, fixed rank and enable.
    always_comb begin : vec_map
        pri_v = '0;
        prog_v = '0;
        en_v = '0;
        fix_v = {48{`EPM_RANK_NONE}};
        fix_v[`EPM_VEC_NMI] = `EPM_RANK_NMI;
        fix_v[`EPM_VEC_HARD] = `EPM_RANK_HARD;
        en_v[`EPM_VEC_NMI] = 1'b1;
        en_v[`EPM_VEC_HARD] = 1'b1;
        for (int i = 0; i < 7; i++) begin
            pri_v[SYS_VEC[i]] = q.shp[i];
            prog_v[SYS_VEC[i]] = 1'b1;
        end
        en_v[`EPM_VEC_MEM] = q.shen[`EPM_SC_MEM_EN];
        en_v[`EPM_VEC_BUS] = q.shen[`EPM_SC_BUS_EN];
        en_v[`EPM_VEC_USE] = q.shen[`EPM_SC_USE_EN];
        en_v[`EPM_VEC_DBG] = q.shen[`EPM_SC_DBG_EN];
        en_v[`EPM_VEC_SUPCALL] = 1'b1;
        en_v[`EPM_VEC_PENDSRV] = 1'b1;
        en_v[`EPM_VEC_TICK] = 1'b1;
        prog_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ] = '1;
        en_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ] = q.en;
        pri_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ] = q.pri;
    end

    // Full rank orders selection; preempt rank drops the subpriority bits.
    for (genvar v = 0; v < `EPM_NUM_VEC; v++) begin : g_rank
        assign full_v[v] = prog_v[v] ? `EPM_RANK_PROG + {1'b0, pri_v[v]} : fix_v[v];
        assign pre_v[v] = prog_v[v] ? `EPM_RANK_PROG + {1'b0, pri_v[v] >> q.grp} : fix_v[v];
    end

    // Finds the best pending request, the running handler and the level left after it ends.
    always_comb begin : pick
        sel_ok = 1'b0;
        sel_vec = '0;
        sel_full = `EPM_RANK_NONE;
        cur_ok = 1'b0;
        cur_vec = '0;
        cur_full = `EPM_RANK_NONE;
        cur_pre = `EPM_RANK_NONE;
        for (int v = 0; v < `EPM_NUM_VEC; v++) begin
            if (q.pend[v] && en_v[v] && full_v[v] < sel_full) begin
                sel_ok = 1'b1;
                sel_vec = 6'(v);
                sel_full = full_v[v];
            end
            if (q.act[v] && full_v[v] < cur_full) begin
                cur_ok = 1'b1;
                cur_vec = 6'(v);
                cur_full = full_v[v];
                cur_pre = pre_v[v];
            end
        end
        aft_pre = `EPM_RANK_NONE;
        for (int v = 0; v < `EPM_NUM_VEC; v++) begin
            if (q.act[v] && 6'(v) != cur_vec && pre_v[v] < aft_pre) begin
                aft_pre = pre_v[v];
            end
        end
    end

    assign sel_pre = pre_v[sel_vec];
    assign preempt_ok = sel_ok && sel_pre < cur_pre;
    assign chain_ok = sel_ok && sel_pre < aft_pre;
    assign use_req = evt.undef | evt.unalign_illegal | evt.bad_state | evt.bad_return
        | (evt.unalign_wh & q.shen[`EPM_SC_UNALIGN]) | (evt.div_zero & q.shen[`EPM_SC_DIV0]);
    assign freq = {evt.supcall_exec, use_req, evt.bus_precise,
        evt.exec_never_fetch | evt.prot_viol};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Register access, event capture, entry and exit sequencing, reset.
    always_comb begin : next_state
        d = q;
        set_v = '0;
        clr_v = '0;
        aset_v = '0;
        aclr_v = '0;
        d.rdata = '0;
        d.o.sp_load = 1'b0;
        d.o.fetch = 1'b0;
        d.o.push = 1'b0;
        d.o.pop = 1'b0;
        d.o.tail = 1'b0;
        // Pin filter: a change counts once the second and third stages agree.
        d.nmi_s = {q.nmi_s[1:0], nmi_pin};
        if (q.nmi_s[1] == q.nmi_s[2]) begin
            d.nmi_lvl = q.nmi_s[2];
        end
        set_v[`EPM_VEC_NMI] = q.nmi_s[1] & q.nmi_s[2] & ~q.nmi_lvl;
        d.irq_prev = irq_in;
        set_v[`EPM_VEC_HARD] = evt.entry_err;
        // Synchronous faults that cannot run now escalate to hard fault.
        for (int i = 0; i < 4; i++) begin
            if (freq[i]) begin
                if (en_v[FLT_VEC[i]] && pre_v[FLT_VEC[i]] < cur_pre) begin
                    set_v[FLT_VEC[i]] = 1'b1;
                end else begin
                    set_v[`EPM_VEC_HARD] = 1'b1;
                end
            end
        end
        if (evt.bus_imprecise) begin
            if (en_v[`EPM_VEC_BUS]) begin
                set_v[`EPM_VEC_BUS] = 1'b1;
            end else begin
                set_v[`EPM_VEC_HARD] = 1'b1;
            end
        end
        if (evt.dbg_req && en_v[`EPM_VEC_DBG] && pre_v[`EPM_VEC_DBG] < cur_pre) begin
            set_v[`EPM_VEC_DBG] = 1'b1;
        end
        set_v[`EPM_VEC_TICK] = evt.tick_zero & evt.tick_int_en;
        // Register writes.
        if (bus.wr) begin
            if (bus.addr == `EPM_OFF_CTRL_STATE) begin
                set_v[`EPM_VEC_NMI] |= bus.wdata[`EPM_CS_NMI_SET];
                set_v[`EPM_VEC_PENDSRV] = bus.wdata[`EPM_CS_PEND_SET];
                clr_v[`EPM_VEC_PENDSRV] = bus.wdata[`EPM_CS_PEND_CLR];
                set_v[`EPM_VEC_TICK] |= bus.wdata[`EPM_CS_TICK_SET];
                clr_v[`EPM_VEC_TICK] = bus.wdata[`EPM_CS_TICK_CLR];
            end else if (bus.addr == `EPM_OFF_SYS_CTRL) begin
                d.shen = bus.wdata[`EPM_SC_LSB +: 6];
            end else if (bus.addr == `EPM_OFF_SYS_PRI) begin
                for (int i = 0; i < 7; i++) begin
                    d.shp[i] = bus.wdata[4 * i +: 3];
                end
            end else if (bus.addr == `EPM_OFF_GROUP) begin
                d.grp = bus.wdata[1:0];
            end else if (bus.addr == `EPM_OFF_SET_EN) begin
                d.en = q.en | bus.wdata[30:0];
            end else if (bus.addr == `EPM_OFF_CLR_EN) begin
                d.en = q.en & ~bus.wdata[30:0];
            end else if (bus.addr == `EPM_OFF_SET_PEND) begin
                set_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ] |= bus.wdata[30:0];
            end else if (bus.addr == `EPM_OFF_CLR_PEND) begin
                clr_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ] = bus.wdata[30:0];
            end else if (bus.addr >= `EPM_OFF_PRIO0 && bus.addr <= `EPM_OFF_PRIO3) begin
                for (int i = 0; i < `EPM_NUM_IRQ; i++) begin
                    if (bus.addr[3:2] == 2'(i / 8)) begin
                        d.pri[i] = bus.wdata[4 * (i % 8) +: 3];
                    end
                end
            end
        end
        // Register reads; unmapped addresses read zero.
        if (bus.rd) begin
            if (bus.addr == `EPM_OFF_CTRL_STATE) begin
                d.rdata[5:0] = cur_vec;
                d.rdata[`EPM_CS_SEL_LSB +: 6] = sel_vec;
                d.rdata[`EPM_CS_NMI_SET] = q.pend[`EPM_VEC_NMI];
                d.rdata[`EPM_CS_PEND_SET] = q.pend[`EPM_VEC_PENDSRV];
                d.rdata[`EPM_CS_TICK_SET] = q.pend[`EPM_VEC_TICK];
            end else if (bus.addr == `EPM_OFF_SYS_CTRL) begin
                d.rdata[`EPM_SC_LSB +: 6] = q.shen;
            end else if (bus.addr == `EPM_OFF_SYS_PRI) begin
                for (int i = 0; i < 7; i++) begin
                    d.rdata[4 * i +: 3] = q.shp[i];
                end
            end else if (bus.addr == `EPM_OFF_GROUP) begin
                d.rdata[1:0] = q.grp;
            end else if (bus.addr == `EPM_OFF_SET_EN || bus.addr == `EPM_OFF_CLR_EN) begin
                d.rdata[30:0] = q.en;
            end else if (bus.addr == `EPM_OFF_SET_PEND || bus.addr == `EPM_OFF_CLR_PEND) begin
                d.rdata[30:0] = q.pend[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ];
            end else if (bus.addr >= `EPM_OFF_PRIO0 && bus.addr <= `EPM_OFF_PRIO3) begin
                for (int i = 0; i < `EPM_NUM_IRQ; i++) begin
                    if (bus.addr[3:2] == 2'(i / 8)) begin
                        d.rdata[4 * (i % 8) +: 3] = q.pri[i];
                    end
                end
            end else if (bus.addr == `EPM_OFF_ACT_IRQ) begin
                d.rdata[30:0] = q.act[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ];
            end else if (bus.addr == `EPM_OFF_SYS_STAT) begin
                d.rdata = {q.pend[15:0], q.act[15:0]};
            end
        end
        // Boot and exception sequencing.
        case (q.st)
            epm_pkg::ST_SP: begin
                d.o.sp_load = 1'b1;
                d.o.fetch = 1'b1;
                d.o.fetch_addr = `EPM_ADDR_SP;
                d.st = epm_pkg::ST_PC;
            end
            epm_pkg::ST_PC: begin
                d.o.fetch = 1'b1;
                d.o.fetch_addr = `EPM_ADDR_RESET;
                d.o.halted = 1'b0;
                d.st = epm_pkg::ST_RUN;
            end
            epm_pkg::ST_RUN: begin
                if (exc_return && cur_ok) begin
                    aclr_v[cur_vec] = 1'b1;
                    if (chain_ok) begin
                        aset_v[sel_vec] = 1'b1;
                        clr_v[sel_vec] = 1'b1;
                        d.o.tail = 1'b1;
                        d.o.fetch = 1'b1;
                        d.o.vec = sel_vec;
                        d.o.fetch_addr = {sel_vec, 2'b00};
                    end else begin
                        d.o.pop = 1'b1;
                    end
                end else if (instr_boundary && preempt_ok) begin
                    aset_v[sel_vec] = 1'b1;
                    clr_v[sel_vec] = 1'b1;
                    d.o.push = 1'b1;
                    d.o.fetch = 1'b1;
                    d.o.vec = sel_vec;
                    d.o.fetch_addr = {sel_vec, 2'b00};
                end
            end
            default: begin
                d.st = epm_pkg::ST_SP;
            end
        endcase
        // A held level re-pends only after its handler ends, an entry made now counting
        // as running, so entry clears it; a new rising edge pends at once.
        set_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ] |= irq_in
            & (~q.irq_prev | ~q.act[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ]
            & ~aset_v[`EPM_VEC_IRQ0 +: `EPM_NUM_IRQ]);
        // A set in the same cycle as a clear wins.
        d.pend = (q.pend & ~clr_v) | set_v;
        d.act = (q.act & ~aclr_v) | aset_v;
        d.o.handler = |d.act;
        // Synchronous reset stops everything wherever it stands.
        if (!reset_n) begin
            d = '0;
            d.st = epm_pkg::ST_SP;
            d.o.halted = 1'b1;
            d.pri = {`EPM_NUM_IRQ{`EPM_PRI_RST}};
            d.shp = {7{`EPM_PRI_RST}};
        end
    end

    // Registers the whole state.
    always_ff @(posedge clk) begin : state_reg
        q <= d;
    end

    assign rdata = q.rdata;
    assign core_out = q.o;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_pri_reset: assert property ($rose(reset_n) |-> q.pri == '0 && q.shp == '0)
        else $error("priority not zero after reset");
    chk_boot_seq: assert property ($rose(reset_n) |=> q.o.sp_load
        && q.o.fetch_addr == 8'h00 ##1 q.o.fetch && !q.o.sp_load
        && q.o.fetch_addr == 8'h04 && !q.o.halted) else $error("boot sequence wrong");
    chk_sw_pend: assert property (bus.wr && bus.addr == 8'h18 && bus.wdata[0]
        |=> q.pend[16] || q.act[16]) else $error("software request not pending");
    chk_nest_active: assert property (q.o.push && $past(q.act) != '0
        |-> $countones(q.act) >= 2) else $error("nested handler lost activity");
    chk_nmi_take: assert property (q.st == epm_pkg::ST_RUN && q.pend[2] && !q.act[2]
        && instr_boundary |=> q.o.vec == 6'h02 && q.o.fetch) else $error("nmi not taken");
    chk_hard_entry: assert property (evt.entry_err |=> q.pend[3] || q.act[3])
        else $error("entry error without hard fault");
    chk_xn_fault: assert property (evt.exec_never_fetch |=> q.pend[4] || q.act[4]
        || q.pend[3] || q.act[3]) else $error("execute-never fetch not faulted");
    chk_dbg_gate: assert property (evt.dbg_req && !q.shen[3] && !q.pend[12]
        |=> !q.pend[12]) else $error("disabled debug monitor pended");
    chk_tick_zero: assert property (evt.tick_zero && evt.tick_int_en
        |=> q.pend[15] || q.act[15]) else $error("tick not raised");
    chk_entry_push: assert property (q.o.push |-> q.o.fetch && !q.o.pop && !q.o.tail
        && $past(sel_pre) < $past(cur_pre)) else $error("entry without strict preemption");
    chk_tail_chain: assert property (q.o.tail |-> q.o.fetch && !q.o.push && !q.o.pop)
        else $error("tail chain touched stack");
    cov_nest: cover property (q.o.push && $countones(q.act) >= 2);
    cov_tail: cover property (q.o.tail);
    cov_act_pend: cover property ((q.act & q.pend) != '0);
endmodule : epm_core
`default_nettype wire

/* tb/epm_core_partner.sv */
/*
 * Core side of the exception priority model: instruction boundaries and handler ends.
 * Assumes the model's clock and its synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module epm_core_partner (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic [7:0] hold_cycles,
    input wire epm_pkg::epm_out_t core_out,
    output logic instr_boundary,
    output logic exc_return
);
    logic [7:0] run_q;
    // ----------------------------------------------------------------------
    // Handler timing
    // ----------------------------------------------------------------------
    // A slow core meets a boundary every other cycle; a zero hold never ends a handler.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            instr_boundary <= 1'b0;
            exc_return <= 1'b0;
            run_q <= 8'h00;
        end else begin
            instr_boundary <= slow ? ~instr_boundary : 1'b1;
            exc_return <= 1'b0;
            run_q <= (core_out.fetch || exc_return) ? 8'h00 : run_q + 8'h01;
            // The count restarts at a vector fetch, and no handler end is raised in a cycle that has a fetch.
            if (core_out.handler && !core_out.fetch && hold_cycles != 8'h00
                && run_q >= hold_cycles) begin
                exc_return <= 1'b1;
                run_q <= 8'h00;
            end
        end
    end
endmodule : epm_core_partner
`default_nettype wire

/* tb/epm_core_tb_top.sv */
/*
 * Self-checking bench: register rows, then entry, nesting, chaining, faults, reset.
 * Assumes the core partner model compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
module epm_core_tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic w; logic [31:0] e;} epm_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    epm_pkg::epm_bus_t bus = '0;
    logic nmi_pin = 1'b0;
    logic [30:0] irq_in = '0;
    epm_pkg::epm_evt_t evt = '0;
    logic slow = 1'b0;
    logic [7:0] hold_cycles = 8'h00;
    logic [31:0] rdata;
    logic instr_boundary;
    logic exc_return;
    epm_pkg::epm_out_t core_out;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    epm_row_t rows [9] = '{
        '{8'h08, 32'h0, 1'b0, 32'h0},
        '{8'h2c, 32'h0, 1'b0, 32'h0},
        '{8'h20, 32'h77777777, 1'b1, 32'h77777777},
        '{8'h20, 32'h0, 1'b1, 32'h0},
        '{8'h18, 32'h1, 1'b1, 32'h1},
        '{8'h1c, 32'h1, 1'b1, 32'h0},
        '{8'h10, 32'h3, 1'b1, 32'h3},
        '{8'h14, 32'h2, 1'b1, 32'h1},
        '{8'h3c, 32'h5, 1'b1, 32'h0}};
    logic [20:0] faults [5] = '{{15'h2000, 6'h04}, {15'h0800, 6'h05}, {15'h0200, 6'h06},
        {15'h0008, 6'h0b}, {15'h0003, 6'h0f}};
    epm_core dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .nmi_pin(nmi_pin),
        .irq_in(irq_in), .instr_boundary(instr_boundary), .exc_return(exc_return), .evt(evt),
        .core_out(core_out));
    epm_core_partner core (.clk(clk), .reset_n(reset_n), .slow(slow), .hold_cycles(hold_cycles),
        .core_out(core_out), .instr_boundary(instr_boundary), .exc_return(exc_return));
    // ----------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------------
    // The clock toggles each half period; a hang ends the run as a failure.
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp, "read data");
    endtask : rd
    // Waits for a vector fetch, then checks its vector, address and stacking.
    task automatic wait_fetch(input logic [5:0] v, input logic push_exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (core_out.fetch !== 1'b1 && n < 40);
        check(core_out.vec, v, "vector");
        check(core_out.fetch_addr, {v, 2'b00}, "vector address");
        check(core_out.push, push_exp, "stack push");
    endtask : wait_fetch
    // Waits for a handler end and checks pop against tail-chain.
    task automatic wait_exit(input logic tail_exp);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((core_out.pop | core_out.tail) !== 1'b1 && n < 40);
        check(core_out.tail, tail_exp, "tail chain");
        check(core_out.pop, !tail_exp, "stack pop");
    endtask : wait_exit
    task automatic do_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(negedge clk);
        check(core_out.halted, 1'b1, "halted in reset");
        check(core_out.handler, 1'b0, "handler in reset");
        @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        check({core_out.sp_load, core_out.fetch_addr}, 9'h100, "stack word fetch");
        @(negedge clk);
        check({core_out.halted, core_out.fetch_addr}, 9'h004, "boot vector fetch");
        $display("Test reset done");
    endtask : do_reset
    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    // A reset first, then register rows, nesting, chaining, faults and a reset mid-handler.
    initial begin
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, rows[i].e);
        end
        $display("Test rows done");
        @(posedge clk);
        irq_in <= 31'h1;
        slow <= 1'b1;
        wait_fetch(6'h10, 1'b1);
        @(posedge clk);
        irq_in <= '0;
        wr(8'h00, 32'h04000000);
        rd(8'h00, 32'h0400f010);
        @(posedge clk);
        nmi_pin <= 1'b1;
        wait_fetch(6'h02, 1'b1);
        rd(8'h30, 32'h1);
        rd(8'h34, 32'h80000004);
        @(posedge clk);
        nmi_pin <= 1'b0;
        hold_cycles <= 8'h03;
        slow <= 1'b0;
        wait_exit(1'b0);
        wait_exit(1'b1);
        check(core_out.vec, 6'h0f, "chained vector");
        wait_exit(1'b0);
        check(core_out.handler, 1'b0, "handler after exit");
        $display("Test nesting done");
        wr(8'h04, 32'h0);
        @(posedge clk);
        evt <= epm_pkg::epm_evt_t'(15'h2004);
        @(posedge clk);
        evt <= '0;
        wait_fetch(6'h03, 1'b1);
        wait_exit(1'b0);
        wr(8'h04, 32'h00070000);
        foreach (faults[i]) begin
            @(posedge clk);
            evt <= epm_pkg::epm_evt_t'(faults[i][20:6]);
            @(posedge clk);
            evt <= '0;
            wait_fetch(faults[i][5:0], 1'b1);
            wait_exit(1'b0);
        end
        $display("Test faults done");
        wr(8'h08, 32'h7);
        wr(8'h10, 32'h1);
        @(posedge clk);
        irq_in <= 31'h1;
        hold_cycles <= 8'h00;
        wait_fetch(6'h10, 1'b1);
        @(posedge clk);
        irq_in <= '0;
        do_reset();
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        complete_run();
    end
endmodule : epm_core_tb_top
`default_nettype wire
